/* board_clk_model.sv */
// Board clock network: host and agent sources and the sync loopback
`timescale 1ns/100ps
`default_nettype none
module board_clk_model (
   input  wire logic i_agent_mode,        // Device strapped as agent
   input  wire logic i_sync_output,       // Device sync output
   output wire logic o_host_clock_input,  // Host clock pin
   output wire logic o_agent_clock_input, // Agent clock pin
   output wire logic o_sync_input         // Sync input pin
);
   logic host_r = 1'b0;
   logic agent_r = 1'b0;
   // 25 MHz and 31.25 MHz sources; edges never meet the system clock rising edges
   always #20 host_r = ~host_r;
   always #16 agent_r = ~agent_r;
   // Host pin tied low in agent mode
   assign o_host_clock_input = host_r & !i_agent_mode;
   assign o_agent_clock_input = agent_r;
   // Same trace delay as every other load on the sync net
   assign #2 o_sync_input = i_sync_output;
endmodule // board_clk_model
`default_nettype wire

/* clk_ratio_gen.v */
// Clock-enable generator with ratio off, 1, 2 or 3
`timescale 1ns/100ps
`default_nettype none
module clk_ratio_gen #(
   parameter W = 2
) (
   input  wire         i_clk_sys, // System clock
   input  wire         i_reset,   // Async reset, high
   input  wire [W-1:0] i_ratio,   // Ratio, 0 is off
   output reg          o_en,      // Pulse per period
   output reg  [W-1:0] o_ratio    // Ratio in effect
);
   localparam [W-1:0] ONE = 1;
   reg [W-1:0] cnt_r;

   // Ratio taken only at a period boundary, so no period is cut short
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cnt_r   <= {W{1'b0}};
         o_en    <= 1'b0;
         o_ratio <= {W{1'b0}};
      end else if (cnt_r == {W{1'b0}}) begin
         o_ratio <= i_ratio;
         o_en    <= (i_ratio != {W{1'b0}});
         cnt_r   <= (i_ratio == {W{1'b0}}) ? {W{1'b0}} : i_ratio - ONE;
      end else begin
         o_en  <= 1'b0;
         cnt_r <= cnt_r - ONE;
      end
   end
endmodule // clk_ratio_gen
`default_nettype wire

/* clk_square_div.v */
// Square-wave divider whose half period changes only on a full period
`timescale 1ns/100ps
`default_nettype none
module clk_square_div #(
   parameter W = 3
) (
   input  wire         i_clk_sys, // System clock
   input  wire         i_reset,   // Async reset, high
   input  wire         i_run,     // Allow new periods
   input  wire [W-1:0] i_half,    // Half period, at least 1
   output reg          o_clk      // Divided clock
);
   localparam [W-1:0] ONE = 1;
   reg [W-1:0] cnt_r;
   reg [W-1:0] half_r;

   // A stop or a new rate takes effect after the low half, never mid-pulse
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cnt_r  <= {W{1'b0}};
         half_r <= ONE;
         o_clk  <= 1'b0;
      end else if (cnt_r != {W{1'b0}}) begin
         cnt_r <= cnt_r - ONE;
      end else if (o_clk) begin
         o_clk <= 1'b0;
         cnt_r <= half_r - ONE;
      end else begin
         half_r <= i_half;
         o_clk  <= i_run;
         cnt_r  <= i_run ? i_half - ONE : {W{1'b0}};
      end
   end
endmodule // clk_square_div
`default_nettype wire

/* clock_ctrl_regs.vh */
// Constants for the clock source and ratio control block
`ifndef CLOCK_CTRL_REGS_VH
`define CLOCK_CTRL_REGS_VH

// Register offsets (byte addresses)
`define OFS_OUTPUT_CLOCK_CONTROL   4'h0
`define OFS_UNIT_CLOCK_CONTROL     4'h4
`define OFS_LOCAL_BUS_CLOCK_CONTROL 4'h8
`define OFS_CONFIG_STATUS          4'hC

// Output clock control fields: enables low, divide selects from bit 8
`define OCC_ENABLE_LSB     0
`define OCC_DIVIDE_LSB     8
`define OCC_RESET          32'h00000000

// Unit clock control fields
`define UCC_SECURITY_LSB   0
`define UCC_PCI_DMA_BIT    4
`define SEC_RATIO_OFF      2'h0
`define SEC_RATIO_FULL     2'h1
`define SEC_RATIO_HALF     2'h2
`define SEC_RATIO_THIRD    2'h3
`define SEC_RATIO_RESET    2'h3
`define PCI_DMA_RESET      1'b1
`define SEC_FULL_MAX_MHZ   166

// Local bus clock control divider field
`define LBC_DIVIDER_LSB    0
`define LBC_DIVIDER_RESET  2'h0

// Reset configuration low field positions
`define RCL_SYS_MULT_LSB   24
`define RCL_VCO_DIV_LSB    28
`define RCL_MEM_RATIO_BIT  30
`define RCL_LB_RATIO_BIT   31
`define RCL_CORE_SEL_LSB   16
`define RCL_ENG_MULT_LSB   8
`define RCL_ENG_DIV_BIT    7

// Reset configuration high strap positions
`define RCH_HOST_BIT       31
`define RCH_CKEN_BIT       30

// Primary source codes
`define SRC_HOST           2'h0
`define SRC_SYNC           2'h1
`define SRC_AGENT          2'h2

`endif

/* clock_source_and_ratio_control.v */
// Clock source selection, output clocks and unit ratio control
`include "clock_ctrl_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module clock_source_and_ratio_control #(
   parameter N_PCI_OUT   = 3,    // Number of PCI clock outputs
   parameter SYS_CLK_MHZ = 100   // System bus clock rate for the full-rate check
) (
   input  wire                 i_clk_sys,               // System clock
   input  wire                 i_reset,                 // Async reset, high
   input  wire                 i_host_clock_input,      // Host clock pin
   input  wire                 i_agent_clock_input,     // Agent clock pin
   input  wire                 i_sync_input,            // Sync input pin
   input  wire                 i_input_divide_pin,      // Divide pin
   input  wire [31:0]          i_reset_config_low,      // Config word low
   input  wire [31:0]          i_reset_config_high,     // Config word high
   input  wire [3:0]           i_addr,                  // Byte address
   input  wire [31:0]          i_wdata,                 // Write data
   input  wire                 i_wr,                    // Write strobe
   input  wire                 i_rd,                    // Read strobe
   output reg  [31:0]          o_rdata,                 // Read data
   output reg                  o_primary_clock,         // Primary clock
   output reg  [1:0]           o_primary_source,        // Source code
   output reg                  o_sync_output,           // Sync output pin
   output reg  [N_PCI_OUT-1:0] o_pci_clock_output_n,    // PCI clocks
   output reg  [N_PCI_OUT-1:0] o_pci_clock_output_n_oe, // PCI enables
   output reg  [4:0]           o_system_pll_multiplier, // System factor
   output reg  [3:0]           o_system_vco_divider,    // VCO divider
   output reg  [6:0]           o_processor_pll_select,  // Core select
   output reg  [4:0]           o_engine_pll_multiplier, // Engine factor
   output reg  [1:0]           o_engine_pll_divider,    // Engine divisor
   output reg  [1:0]           o_memory_clock_ratio,    // Memory factor
   output reg  [1:0]           o_local_bus_ratio,       // Local bus factor
   output reg                  o_config_reserved,       // Reserved code
   output reg                  o_memory_bus_clock_out,  // Memory clock
   output reg                  o_memory_bus_clock_out_n, // Complement
   output reg                  o_local_bus_clock_out,   // Local clock
   output reg                  o_local_sync_output,     // Local sync
   output reg                  o_security_clk_en,       // Security enable
   output reg                  o_pci_dma_clk_en         // PCI/DMA enable
);
   // Captured configuration
   reg                  cap_done_r;
   reg  [31:0]          rcl_r;
   reg                  host_mode_r;
   reg                  cken_r;
   reg                  in_div_r;
   // Software registers
   reg  [N_PCI_OUT-1:0] pci_en_r;
   reg  [N_PCI_OUT-1:0] pci_div_r;
   reg  [1:0]           sec_ratio_r;
   reg                  pci_dma_on_r;
   reg  [1:0]           lb_div_r;
   reg                  sec_refused_r;
   // Clock sampling
   reg                  host_clk_r;
   reg                  host_half_r;
   reg  [2:0]           lb_half_nxt;
   reg  [31:0]          rdata_nxt;
   reg                  prim_nxt;
   reg  [1:0]           src_nxt;
   wire                 sec_en;
   wire [1:0]           sec_ratio_now;
   wire                 pci_dma_en;
   wire                 mem_div_clk;
   wire                 lb_div_clk;
   wire                 cfg_host_bit;
   wire                 cfg_cken_bit;
   wire [3:0]           sys_code;
   wire [1:0]           vco_code;
   wire [4:0]           eng_code;
   wire                 full_allowed;

   assign cfg_host_bit = i_reset_config_high[`RCH_HOST_BIT];
   assign cfg_cken_bit = i_reset_config_high[`RCH_CKEN_BIT];
   assign sys_code     = rcl_r[`RCL_SYS_MULT_LSB +: 4];
   assign vco_code     = rcl_r[`RCL_VCO_DIV_LSB +: 2];
   assign eng_code     = rcl_r[`RCL_ENG_MULT_LSB +: 5];
   // Full rate is legal only for slow system clocks
   assign full_allowed = (SYS_CLK_MHZ <= `SEC_FULL_MAX_MHZ);

   // Config words and divide pin caught once, after release
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cap_done_r  <= 1'b0;
         rcl_r       <= 32'h00000000;
         host_mode_r <= 1'b0;
         cken_r      <= 1'b0;
         in_div_r    <= 1'b0;
      end else if (!cap_done_r) begin
         cap_done_r  <= 1'b1;
         rcl_r       <= i_reset_config_low;
         host_mode_r <= cfg_host_bit;
         cken_r      <= cfg_cken_bit;
         // Agent mode ignores the divide pin, which the board ties low
         in_div_r    <= cfg_host_bit & i_input_divide_pin;
      end
   end

   // Primary source selection from the straps
   always @* begin
      if (host_mode_r && cken_r) begin
         src_nxt  = `SRC_HOST;
         prim_nxt = host_clk_r;
      end else if (host_mode_r) begin
         src_nxt  = `SRC_SYNC;
         prim_nxt = i_sync_input;
      end else begin
         src_nxt  = `SRC_AGENT;
         prim_nxt = i_agent_clock_input;
      end
   end

   // Host clock sampling; halver toggles on each rising edge
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         host_clk_r  <= 1'b0;
         host_half_r <= 1'b0;
      end else begin
         host_clk_r <= i_host_clock_input;
         if (i_host_clock_input && !host_clk_r) begin
            host_half_r <= ~host_half_r;
         end
      end
   end

   // Sync and PCI outputs; PCI undriven and sync held low outside host output mode
   always @(posedge i_clk_sys or posedge i_reset) begin : pci_out
      integer k;
      if (i_reset) begin
         o_primary_clock         <= 1'b0;
         o_primary_source        <= `SRC_HOST;
         o_sync_output           <= 1'b0;
         o_pci_clock_output_n    <= {N_PCI_OUT{1'b0}};
         o_pci_clock_output_n_oe <= {N_PCI_OUT{1'b0}};
      end else begin
         o_primary_clock  <= prim_nxt;
         o_primary_source <= src_nxt;
         // The board returns this pin to the sync input with matched delay
         o_sync_output <= (src_nxt == `SRC_HOST) & (in_div_r ? host_half_r : host_clk_r);
         for (k = 0; k < N_PCI_OUT; k = k + 1) begin
            o_pci_clock_output_n_oe[k] <= (src_nxt == `SRC_HOST) & pci_en_r[k];
            o_pci_clock_output_n[k]    <= (src_nxt == `SRC_HOST) & pci_en_r[k]
                                          & (pci_div_r[k] ? host_half_r : host_clk_r);
         end
      end
   end

   // Decoded factors for the PLL stages
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_system_pll_multiplier <= 5'h00;
         o_system_vco_divider    <= 4'h0;
         o_processor_pll_select  <= 7'h00;
         o_engine_pll_multiplier <= 5'h00;
         o_engine_pll_divider    <= 2'h1;
         o_memory_clock_ratio    <= 2'h1;
         o_local_bus_ratio       <= 2'h1;
         o_config_reserved       <= 1'b0;
      end else begin
         // System clock is the primary input times this factor
         if (sys_code == 4'h0) begin
            o_system_pll_multiplier <= 5'h10;
         end else if (sys_code == 4'h1) begin
            o_system_pll_multiplier <= 5'h00;
         end else begin
            o_system_pll_multiplier <= {1'b0, sys_code};
         end
         case (vco_code)
            2'h0:    o_system_vco_divider <= 4'h4;
            2'h1:    o_system_vco_divider <= 4'h8;
            2'h2:    o_system_vco_divider <= 4'h2;
            default: o_system_vco_divider <= 4'h0;
         endcase
         // Core stage multiplies the system clock; its table lives in the core
         o_processor_pll_select  <= rcl_r[`RCL_CORE_SEL_LSB +: 7];
         o_engine_pll_multiplier <= (eng_code == 5'h00) ? 5'h10 : eng_code;
         o_engine_pll_divider    <= 2'h1 + {1'b0, rcl_r[`RCL_ENG_DIV_BIT]};
         o_memory_clock_ratio    <= 2'h1 + {1'b0, rcl_r[`RCL_MEM_RATIO_BIT]};
         o_local_bus_ratio       <= 2'h1 + {1'b0, rcl_r[`RCL_LB_RATIO_BIT]};
         o_config_reserved       <= cap_done_r & ((sys_code == 4'h1) | (vco_code == 2'h3)
                                    | (eng_code == 5'h01));
      end
   end

   // Register writes; a full-rate request on a fast system clock is refused
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         pci_en_r      <= {N_PCI_OUT{1'b0}};
         pci_div_r     <= {N_PCI_OUT{1'b0}};
         sec_ratio_r   <= `SEC_RATIO_RESET;
         pci_dma_on_r  <= `PCI_DMA_RESET;
         lb_div_r      <= `LBC_DIVIDER_RESET;
         sec_refused_r <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == `OFS_OUTPUT_CLOCK_CONTROL) begin
            pci_en_r  <= i_wdata[`OCC_ENABLE_LSB +: N_PCI_OUT];
            pci_div_r <= i_wdata[`OCC_DIVIDE_LSB +: N_PCI_OUT];
         end else if (i_addr == `OFS_UNIT_CLOCK_CONTROL) begin
            if ((i_wdata[`UCC_SECURITY_LSB +: 2] == `SEC_RATIO_FULL) && !full_allowed) begin
               sec_refused_r <= 1'b1;
            end else begin
               sec_ratio_r   <= i_wdata[`UCC_SECURITY_LSB +: 2];
               sec_refused_r <= 1'b0;
            end
            // PCI and DMA complex has no rate choice, only on or off
            pci_dma_on_r <= i_wdata[`UCC_PCI_DMA_BIT];
         end else if (i_addr == `OFS_LOCAL_BUS_CLOCK_CONTROL) begin
            lb_div_r <= i_wdata[`LBC_DIVIDER_LSB +: 2];
         end
      end
   end

   // Read data mux; unmapped addresses read zero
   always @* begin
      rdata_nxt = 32'h00000000;
      if (i_addr == `OFS_OUTPUT_CLOCK_CONTROL) begin
         rdata_nxt[`OCC_ENABLE_LSB +: N_PCI_OUT] = pci_en_r;
         rdata_nxt[`OCC_DIVIDE_LSB +: N_PCI_OUT] = pci_div_r;
      end else if (i_addr == `OFS_UNIT_CLOCK_CONTROL) begin
         rdata_nxt[`UCC_SECURITY_LSB +: 2] = sec_ratio_r;
         rdata_nxt[`UCC_PCI_DMA_BIT]       = pci_dma_on_r;
      end else if (i_addr == `OFS_LOCAL_BUS_CLOCK_CONTROL) begin
         rdata_nxt[`LBC_DIVIDER_LSB +: 2] = lb_div_r;
      end else if (i_addr == `OFS_CONFIG_STATUS) begin
         rdata_nxt[1:0]   = o_primary_source;
         rdata_nxt[2]     = in_div_r;
         rdata_nxt[3]     = o_config_reserved;
         rdata_nxt[4]     = sec_refused_r;
         rdata_nxt[6:5]   = sec_ratio_now;
         rdata_nxt[12:8]  = o_system_pll_multiplier;
         rdata_nxt[19:16] = o_system_vco_divider;
         rdata_nxt[28:24] = o_engine_pll_multiplier;
      end
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 32'h00000000;
      end else begin
         o_rdata <= i_rd ? rdata_nxt : 32'h00000000;
      end
   end

   // Unit clock enables; security counts one, two or three cycles per pulse
   clk_ratio_gen #(.W(2)) u_sec_gen (
      .i_clk_sys   (i_clk_sys),
      .i_reset     (i_reset),
      .i_ratio     (sec_ratio_r),
      .o_en        (sec_en),
      .o_ratio     (sec_ratio_now)
   );

   clk_ratio_gen #(.W(1)) u_pci_dma_gen (
      .i_clk_sys   (i_clk_sys),
      .i_reset     (i_reset),
      .i_ratio     (pci_dma_on_r),
      .o_en        (pci_dma_en),
      .o_ratio     ()
   );

   // Memory bus clock is the system clock halved
   clk_square_div #(.W(3)) u_mem_div (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_run     (cap_done_r),
      .i_half    (3'h1),
      .o_clk     (mem_div_clk)
   );

   // Local bus divider code picks half period 1, 2 or 4 cycles
   always @* begin
      case (lb_div_r)
         2'h0:    lb_half_nxt = 3'h1;
         2'h1:    lb_half_nxt = 3'h2;
         default: lb_half_nxt = 3'h4;
      endcase
   end

   clk_square_div #(.W(3)) u_lb_div (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_run     (cap_done_r),
      .i_half    (lb_half_nxt),
      .o_clk     (lb_div_clk)
   );

   // Output flops; the pair keeps true and complement from the same edge
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_memory_bus_clock_out   <= 1'b0;
         o_memory_bus_clock_out_n <= 1'b1;
         o_local_bus_clock_out    <= 1'b0;
         o_local_sync_output      <= 1'b0;
         o_security_clk_en        <= 1'b0;
         o_pci_dma_clk_en         <= 1'b0;
      end else begin
         o_memory_bus_clock_out   <= mem_div_clk;
         o_memory_bus_clock_out_n <= ~mem_div_clk;
         o_local_bus_clock_out    <= lb_div_clk;
         o_local_sync_output      <= lb_div_clk;
         o_security_clk_en        <= sec_en;
         o_pci_dma_clk_en         <= pci_dma_en;
      end
   end
endmodule // clock_source_and_ratio_control
`default_nettype wire

/* clock_source_and_ratio_control_properties.sv */
// Port assertions for the clock source and ratio control block
`timescale 1ns/100ps
`default_nettype none
module clock_ctrl_properties #(
   parameter N_PCI_OUT = 3
) (
   input wire logic                 i_clk_sys,                // Clock
   input wire logic                 i_reset,                  // Reset
   input wire logic [31:0]          i_reset_config_low,       // Config low
   input wire logic [31:0]          i_reset_config_high,      // Config high
   input wire logic [1:0]           o_primary_source,         // Source code
   input wire logic                 o_sync_output,            // Sync out
   input wire logic [N_PCI_OUT-1:0] o_pci_clock_output_n,     // Outputs
   input wire logic [N_PCI_OUT-1:0] o_pci_clock_output_n_oe,  // Enables
   input wire logic [4:0]           o_system_pll_multiplier,  // Factor
   input wire logic [3:0]           o_system_vco_divider,     // Divider
   input wire logic [1:0]           o_memory_clock_ratio,     // Ratio
   input wire logic                 o_memory_bus_clock_out,   // True side
   input wire logic                 o_memory_bus_clock_out_n, // Complement
   input wire logic                 o_local_bus_clock_out,    // Local clock
   input wire logic                 o_local_sync_output,      // Local sync
   input wire logic                 o_security_clk_en,        // Security
   input wire logic                 o_pci_dma_clk_en          // PCI and DMA
);
   logic [2:0] up_r;
   wire logic [3:0] sm = i_reset_config_low[27:24];
   wire logic [1:0] vd = i_reset_config_low[29:28];
   wire logic [1:0] src_w = !i_reset_config_high[31] ? 2'h2 : i_reset_config_high[30] ? 2'h0 : 2'h1;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // Edges since release; decoded outputs settle only after the capture edge
   always_ff @(posedge i_clk_sys or posedge i_reset)
      if (i_reset) up_r <= 3'h0;
      else if (up_r != 3'h7) up_r <= up_r + 3'h1;
   a_source_select: assert property (up_r > 3'h2 |-> o_primary_source == src_w)
      else $error("primary source differs from straps");
   a_oe_host_only: assert property (o_pci_clock_output_n_oe != '0 |-> o_primary_source == 2'h0)
      else $error("output enabled outside host output mode");
   a_undriven_low: assert property ((o_pci_clock_output_n & ~o_pci_clock_output_n_oe) == '0)
      else $error("disabled output not low");
   a_sync_quiet: assert property (up_r > 3'h2 && src_w != 2'h0 |-> !o_sync_output)
      else $error("sync output active without host outputs");
   a_sys_mult: assert property (up_r > 3'h2 |->
      o_system_pll_multiplier == (sm == 4'h0 ? 5'h10 : sm == 4'h1 ? 5'h00 : {1'b0, sm}))
      else $error("system multiplier decode wrong");
   a_vco_div: assert property (up_r > 3'h2 |->
      o_system_vco_divider == (vd == 2'h0 ? 4'h4 : vd == 2'h1 ? 4'h8 : vd == 2'h2 ? 4'h2 : 4'h0))
      else $error("vco divider decode wrong");
   a_mem_ratio: assert property (up_r > 3'h2 |-> o_memory_clock_ratio == {1'b0, i_reset_config_low[30]} + 2'h1)
      else $error("memory ratio wrong");
   a_mem_pair: assert property (o_memory_bus_clock_out_n == !o_memory_bus_clock_out)
      else $error("memory clock pair not complementary");
   a_mem_half: assert property (up_r > 3'h2 |-> o_memory_bus_clock_out != $past(o_memory_bus_clock_out))
      else $error("memory clock not half rate");
   a_lb_same: assert property (o_local_bus_clock_out == o_local_sync_output)
      else $error("local clock and sync differ");
   a_sec_third: assert property (up_r < 3'h6 && o_security_clk_en |-> ##1 !o_security_clk_en [*2] ##1 o_security_clk_en)
      else $error("security default not one third");
   a_dma_default: assert property (up_r == 3'h4 |-> o_pci_dma_clk_en)
      else $error("PCI and DMA clock off after reset");
endmodule // clock_ctrl_properties
bind clock_source_and_ratio_control clock_ctrl_properties #(.N_PCI_OUT(N_PCI_OUT)) i_clock_ctrl_properties (
   .i_clk_sys, .i_reset, .i_reset_config_low, .i_reset_config_high, .o_primary_source, .o_sync_output,
   .o_pci_clock_output_n, .o_pci_clock_output_n_oe, .o_system_pll_multiplier, .o_system_vco_divider,
   .o_memory_clock_ratio, .o_memory_bus_clock_out, .o_memory_bus_clock_out_n, .o_local_bus_clock_out,
   .o_local_sync_output, .o_security_clk_en, .o_pci_dma_clk_en);
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the clock source and ratio control block
`include "clock_ctrl_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic             i_clk_sys = 1'b0;
   logic             i_reset = 1'b1;
   logic             div_pin = 1'b0;
   logic             i_wr = 1'b0;
   logic             i_rd = 1'b0;
   logic [3:0]       i_addr = 4'h0;
   logic [31:0]      i_wdata = 32'h0;
   logic [31:0]      cfg_l = 32'h0;
   logic [31:0]      cfg_h = 32'h0;
   logic [31:0]      d;
   logic [31:0]      rv [5];
   logic [3:0]       adr [5] = '{4'h0, 4'h4, 4'h8, 4'h2, 4'hC};
   logic [1:0]       codes [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
   wire logic [31:0] rdata;
   wire logic [2:0]  pci, pci_oe;
   wire logic [1:0]  src, eng_div, lb_ratio;
   wire logic [6:0]  core;
   wire logic        host_clk, agent_clk, sync_in, sync_out, mem, lb, sec_en, dma_en;
   wire logic [5:0]  mon = {sec_en, lb, mem, sync_out, pci[1:0]};
   int               miscompares = 0;
   int               comparisons = 0;
   int               seed, k, hi, ch, eff;
   clock_source_and_ratio_control #(.N_PCI_OUT(3), .SYS_CLK_MHZ(200)) i_clock_source_and_ratio_control (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_host_clock_input(host_clk), .i_agent_clock_input(agent_clk),
      .i_sync_input(sync_in), .i_input_divide_pin(div_pin), .i_reset_config_low(cfg_l),
      .i_reset_config_high(cfg_h), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(rdata), .o_primary_clock(), .o_primary_source(src), .o_sync_output(sync_out),
      .o_pci_clock_output_n(pci), .o_pci_clock_output_n_oe(pci_oe), .o_system_pll_multiplier(),
      .o_system_vco_divider(), .o_processor_pll_select(core), .o_engine_pll_multiplier(),
      .o_engine_pll_divider(eng_div), .o_memory_clock_ratio(), .o_local_bus_ratio(lb_ratio),
      .o_config_reserved(), .o_memory_bus_clock_out(mem), .o_memory_bus_clock_out_n(),
      .o_local_bus_clock_out(lb), .o_local_sync_output(), .o_security_clk_en(sec_en), .o_pci_dma_clk_en(dma_en));
   board_clk_model i_board_clk_model (.i_agent_mode(!cfg_h[31]), .i_sync_output(sync_out),
      .o_host_clock_input(host_clk), .o_agent_clock_input(agent_clk), .o_sync_input(sync_in));
   // 100 MHz system clock
   always #5 i_clk_sys = ~i_clk_sys;
   // Expected status word from straps and config
   function automatic logic [31:0] exp_status(input logic [31:0] cl, ch, input logic dp);
      int src_e, sm, vd, em, rsv;
      src_e = !ch[31] ? 2 : ch[30] ? 0 : 1;
      sm = cl[27:24] == 0 ? 16 : cl[27:24] == 1 ? 0 : cl[27:24];
      vd = cl[29:28] == 0 ? 4 : cl[29:28] == 1 ? 8 : cl[29:28] == 2 ? 2 : 0;
      em = cl[12:8] == 0 ? 16 : cl[12:8];
      rsv = cl[27:24] == 1 || cl[29:28] == 3 || cl[12:8] == 1;
      return {3'h0, em[4:0], 4'h0, vd[3:0], 3'h0, sm[4:0], 3'h3, 1'b0, rsv[0], dp && src_e != 2, src_e[1:0]};
   endfunction
   // Exact unless slack is given; free-running clock counts need two for phase
   task automatic chk(input string what, input logic signed [31:0] want, got, input int tol = 0);
      comparisons++;
      if (got !== want && (tol == 0 || got > want + tol || got < want - tol)) begin
         $display("[ERR] %s expected %h seen %h", what, want, got);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
      @(posedge i_clk_sys) i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge i_clk_sys) {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clk_sys) i_rd <= 1'b0;
      #1 v = rdata;
   endtask
   // High cycles and changes of one output over 80 cycles
   task automatic meas(input int sel, output int h, c);
      logic p;
      h = 0;
      c = 0;
      @(posedge i_clk_sys) #1 p = mon[sel];
      repeat (80) begin
         @(posedge i_clk_sys) #1 h += mon[sel];
         c += (mon[sel] != p);
         p = mon[sel];
      end
   endtask
   // Config held through reset; captured once after release
   task automatic do_reset(input logic [31:0] cl, ch, input logic dp);
      @(posedge i_clk_sys) {i_reset, cfg_l, cfg_h, div_pin} <= {1'b1, cl, ch, dp};
      repeat (12) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
   endtask
   task test_done;
      $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (100000) @(posedge i_clk_sys);
      miscompares++;
      test_done;
   end
   // Main sequence
   initial begin
      seed = 63;
      // All system multiplier and divider codes, three strap modes
      for (k = 0; k < 16; k++) begin
         d = $random(seed);
         d[29:24] = {k[1:0], k[3:0]};
         do_reset(d, {k % 3 == 2 ? 2'b00 : {1'b1, k % 3 == 0}, 30'h0}, k % 3 != 2 && seed[0]);
         rd(`OFS_CONFIG_STATUS, d);
         chk("status", exp_status(cfg_l, cfg_h, div_pin), d);
         chk("engine divider", {1'b0, cfg_l[7]} + 2'h1, eng_div);
         chk("local ratio", {1'b0, cfg_l[31]} + 2'h1, lb_ratio);
         chk("core select", cfg_l[22:16], core);
      end
      // Reset values; unmapped and status writes must have no effect
      wr(4'h2, 32'hFFFFFFFF);
      wr(`OFS_CONFIG_STATUS, 32'hFFFFFFFF);
      rv = '{32'h0, 32'h13, 32'h0, 32'h0, exp_status(cfg_l, cfg_h, div_pin)};
      foreach (adr[i]) begin
         rd(adr[i], d);
         chk("register", rv[i], d);
      end
      wr(`OFS_OUTPUT_CLOCK_CONTROL, 32'h00000107);
      repeat (4) @(posedge i_clk_sys);
      #1 chk("enables", 32'h7, pci_oe);
      meas(1, hi, ch);
      chk("full output", 40, ch, 2);
      meas(0, hi, ch);
      chk("halved output", 20, ch, 2);
      meas(2, hi, ch);
      chk("sync output", 40 / (1 + div_pin), ch, 2);
      meas(3, hi, ch);
      chk("memory clock", 80, ch, 2);
      wr(`OFS_OUTPUT_CLOCK_CONTROL, 32'h00000005);
      repeat (4) @(posedge i_clk_sys);
      #1 chk("enables", 32'h5, pci_oe);
      for (k = 0; k < 4; k++) begin
         wr(`OFS_LOCAL_BUS_CLOCK_CONTROL, k);
         repeat (20) @(posedge i_clk_sys);
         meas(4, hi, ch);
         chk("local clock", 80 >> (k > 2 ? 2 : k), ch, 2);
      end
      // Full rate refused at this system rate; old ratio stays
      eff = 3;
      foreach (codes[i]) begin
         if (codes[i] != 2'h1) eff = codes[i];
         wr(`OFS_UNIT_CLOCK_CONTROL, {27'h0, 1'b1, 2'h0, codes[i]});
         repeat (8) @(posedge i_clk_sys);
         meas(5, hi, ch);
         chk("security pulses", eff == 0 ? 0 : 80 / eff, hi, 2);
         rd(`OFS_CONFIG_STATUS, d);
         chk("security state", {eff[1:0], codes[i] == 2'h1}, d[6:4]);
      end
      wr(`OFS_UNIT_CLOCK_CONTROL, 32'h3);
      repeat (3) @(posedge i_clk_sys);
      #1 chk("dma enable", 32'h0, dma_en);
      test_done;
   end
endmodule // tb_top
`default_nettype wire
